// ==== clgs_current_loop_gain_schedule.sv ====
// Contract
// RULE1 - table holds 256 entries covering zero to 1.62 times drive peak current
// RULE2 - index N means command equal to N over 157 times drive peak
// RULE3 - entries are 0..100 percent; applied gain is base gain times entry
// RULE4 - with memory version at least 0.03 and auto setup 1, entries computed, read-only
// RULE5 - without motor memory entries are writable and entered by the host
// RULE6 - entry access goes through the table pointer; entries default to 0
// RULE7 - dump returns all 256 entries as index, value in ascending order
// RULE8 - table pointer takes 0 to 255 and resets to 0
// RULE9 - velocity feed-forward gain 0 to 2, default 0, scales nominal term
// RULE10 - velocity feed-forward gain applies only in position mode 2
// RULE11 - negative limit ranges from minus drive peak to 0, default minus peak
// RULE12 - command clamped by negative limit, motor peak and foldback limit
// RULE13 - base q gain settable from 0 to 2000 V/A
// RULE14 - index from command magnitude times 157 over drive peak, saturating at 255
// RULE15 - scheduled gain refreshed every current-loop cycle
`timescale 1ns/1ps
module clgs_current_loop_gain_schedule (
	// clock, reset, enable
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	input  wire logic               ce_i,
	// parameter access port
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	input  wire logic [15:0]        addr_i,
	input  wire logic [31:0]        wdata_i,
	output logic      [31:0]        rdata_o,
	output logic                    rd_valid_o,
	// drive and motor settings, all on clk_i
	input  wire logic [31:0]        q_prop_gain_i,
	input  wire logic [31:0]        drive_peak_current_i,
	input  wire logic [31:0]        motor_peak_current_i,
	input  wire logic [31:0]        foldback_limit_i,
	input  wire logic [15:0]        feedback_memory_version_i,
	input  wire logic               motor_auto_setup_i,
	input  wire logic [31:0]        motor_saturation_inductance_i,
	input  wire logic [1:0]         operating_mode_select_i,
	// current loop
	input  wire logic               loop_tick_i,
	input  wire logic signed [31:0] q_current_command_i,
	input  wire logic signed [31:0] vel_ff_nominal_i,
	output logic      [31:0]        sched_prop_gain_o,
	output logic      [7:0]         active_index_o,
	output logic signed [31:0]      q_current_limited_o,
	output logic signed [31:0]      vel_ff_term_o,
	// table dump stream
	input  wire logic               gain_table_dump_i,
	output logic                    dump_valid_o,
	output logic      [7:0]         dump_index_o,
	output logic      [16:0]        dump_value_o,
	output logic                    auto_table_o
);
	function automatic logic signed [31:0] smax(input logic signed [31:0] a,
		input logic signed [31:0] b);
		smax = (a > b) ? a : b;
	endfunction

	function automatic logic signed [31:0] smin(input logic signed [31:0] a,
		input logic signed [31:0] b);
		smin = (a < b) ? a : b;
	endfunction

	logic [16:0]          gain_table [clgs_pkg::TABLE_DEPTH]; // RULE1
	logic [7:0]           gain_table_pointer;
	logic [31:0]          velocity_ff_gain;
	logic signed [31:0]   negative_user_limit;
	logic                 limit_is_default;
	logic [7:0]           walk_index;
	clgs_pkg::clgs_state_type state;
	clgs_pkg::clgs_state_type next_state;

	// decode
	wire                  auto_mode   = (feedback_memory_version_i >= clgs_pkg::MEMVER_MIN)
	                                    && motor_auto_setup_i; // RULE4
	wire                  hit_vff     = addr_i == clgs_pkg::VEL_FF_GAIN_OFS;
	wire                  hit_neg     = addr_i == clgs_pkg::NEG_LIMIT_OFS;
	wire                  hit_ptr     = addr_i == clgs_pkg::TABLE_POINTER_OFS;
	wire                  hit_entry   = addr_i == clgs_pkg::TABLE_ENTRY_OFS;
	wire                  entry_wr_ok = wr_i && hit_entry && !auto_mode; // RULE5
	wire signed [31:0]    neg_peak    = -$signed(drive_peak_current_i);
	wire signed [31:0]    eff_neg_lim = limit_is_default ? neg_peak : negative_user_limit; // RULE11
	wire signed [31:0]    wdata_s     = $signed(wdata_i);
	wire signed [31:0]    neg_wr_val  = smin(smax(wdata_s, neg_peak), 32'sd0); // RULE11
	wire [31:0]           vff_wr_val  = (wdata_i > clgs_pkg::VFF_MAX) ?
	                                    clgs_pkg::VFF_MAX : wdata_i; // RULE9
	wire [16:0]           entry_wr    = (wdata_i > {15'h0000, clgs_pkg::PCT_FULL}) ?
	                                    clgs_pkg::PCT_FULL : wdata_i[16:0]; // RULE3

	// index from command magnitude, saturating at the table end
	wire signed [31:0]    cmd_s       = q_current_command_i;
	wire [31:0]           cmd_mag     = cmd_s[31] ? 32'(-cmd_s) : 32'(cmd_s);
	wire [39:0]           cmd_scaled  = 40'(cmd_mag) * 40'(clgs_pkg::INDEX_PER_PEAK); // RULE2
	wire [39:0]           idx_raw     = (drive_peak_current_i == 32'h00000000) ? 40'hffffffffff :
	                                    cmd_scaled / 40'(drive_peak_current_i); // RULE14
	wire [7:0]            idx_sat     = (idx_raw > 40'(clgs_pkg::INDEX_MAX)) ?
	                                    clgs_pkg::INDEX_MAX : idx_raw[7:0]; // RULE14

	// scheduled gain; base gain clamped to its range first
	wire [31:0]           kp_clamped  = (q_prop_gain_i > clgs_pkg::KP_MAX) ?
	                                    clgs_pkg::KP_MAX : q_prop_gain_i; // RULE13
	wire [48:0]           kp_product  = 49'(kp_clamped) * 49'(gain_table[idx_sat]); // RULE3
	wire [31:0]           kp_sched    = 32'(kp_product / 49'(clgs_pkg::PCT_FULL));

	// command clamp, symmetric motor peak and foldback, user limit on the negative side
	wire signed [31:0]    mpk         = $signed(motor_peak_current_i);
	wire signed [31:0]    fbk         = $signed(foldback_limit_i);
	wire signed [31:0]    hi_lim      = smin(mpk, fbk);
	wire signed [31:0]    lo_lim      = smax(eff_neg_lim, -hi_lim);
	wire signed [31:0]    cmd_clamped = smax(smin(cmd_s, hi_lim), lo_lim); // RULE12

	// feed-forward only in position mode, zero term otherwise
	wire signed [63:0]    vff_prod    = 64'(vel_ff_nominal_i) * $signed({32'h0, velocity_ff_gain});
	wire signed [31:0]    vff_scaled  = 32'(vff_prod / $signed({32'h0, clgs_pkg::VFF_UNITY})); // RULE9
	wire signed [31:0]    vff_next    = (operating_mode_select_i == clgs_pkg::OPMODE_POSITION) ?
	                                    vff_scaled : 32'sd0; // RULE10

	// auto fill: full gain up to drive peak, then falls by the saturation slope
	wire [7:0]            over_peak   = walk_index - clgs_pkg::INDEX_PER_PEAK;
	wire [39:0]           sat_drop    = 40'(over_peak) * 40'(motor_saturation_inductance_i);
	wire [16:0]           fill_value  = (walk_index <= clgs_pkg::INDEX_PER_PEAK) ? clgs_pkg::PCT_FULL :
	                                    (sat_drop >= 40'(clgs_pkg::PCT_FULL)) ? 17'h00000 :
	                                    clgs_pkg::PCT_FULL - sat_drop[16:0]; // RULE4
	wire                  walk_last   = walk_index == clgs_pkg::INDEX_MAX;

	// read mux
	wire [31:0]           rd_mux      = hit_vff   ? velocity_ff_gain :
	                                    hit_neg   ? 32'(eff_neg_lim) :
	                                    hit_ptr   ? {24'h000000, gain_table_pointer} :
	                                    hit_entry ? {15'h0000, gain_table[gain_table_pointer]} : // RULE6
	                                    32'h00000000;

	// dump is served before a refill in idle; a fill ignores the dump input, so a request must still stand when the fill returns to idle
	always_comb begin
		next_state = state;
		case (state)
			clgs_pkg::CLGS_IDLE: begin
				if (gain_table_dump_i) begin
					next_state = clgs_pkg::CLGS_DUMP; // RULE7
				end else if (auto_mode) begin
					next_state = clgs_pkg::CLGS_FILL; // RULE4
				end
			end
			clgs_pkg::CLGS_DUMP: begin
				if (walk_last) begin
					next_state = clgs_pkg::CLGS_IDLE;
				end
			end
			clgs_pkg::CLGS_FILL: begin
				if (walk_last || !auto_mode) begin
					next_state = clgs_pkg::CLGS_IDLE;
				end
			end
			default: next_state = clgs_pkg::CLGS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state      <= clgs_pkg::CLGS_IDLE;
			walk_index <= 8'h00;
		end else if (ce_i) begin
			state      <= next_state;
			walk_index <= (state == clgs_pkg::CLGS_IDLE) ? 8'h00 : walk_index + 8'h01;
		end
	end

	// table storage; a host write is refused while the fill owns the table
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < clgs_pkg::TABLE_DEPTH; i++) begin
				gain_table[i] <= clgs_pkg::ENTRY_RESET; // RULE6
			end
		end else if (ce_i) begin
			if (state == clgs_pkg::CLGS_FILL && auto_mode) begin
				gain_table[walk_index] <= fill_value; // RULE4
			end else if (entry_wr_ok) begin
				gain_table[gain_table_pointer] <= entry_wr; // RULE6
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gain_table_pointer  <= clgs_pkg::POINTER_RESET; // RULE8
			velocity_ff_gain    <= clgs_pkg::VFF_RESET; // RULE9
			negative_user_limit <= 32'sd0;
			limit_is_default    <= 1'b1; // RULE11
		end else if (ce_i && wr_i) begin
			if (hit_ptr) begin
				gain_table_pointer <= wdata_i[7:0]; // RULE8
			end
			if (hit_vff) begin
				velocity_ff_gain <= vff_wr_val;
			end
			if (hit_neg) begin
				negative_user_limit <= neg_wr_val;
				limit_is_default    <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o    <= 32'h00000000;
			rd_valid_o <= 1'b0;
		end else if (ce_i) begin
			rdata_o    <= rd_i ? rd_mux : 32'h00000000;
			rd_valid_o <= rd_i;
		end
	end

	// loop outputs move only on the loop tick so the regulator sees one value per cycle
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sched_prop_gain_o   <= 32'h00000000;
			active_index_o      <= 8'h00;
			q_current_limited_o <= 32'sd0;
			vel_ff_term_o       <= 32'sd0;
		end else if (ce_i && loop_tick_i) begin
			sched_prop_gain_o   <= kp_sched; // RULE15
			active_index_o      <= idx_sat; // RULE14
			q_current_limited_o <= cmd_clamped; // RULE12
			vel_ff_term_o       <= vff_next; // RULE10
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dump_valid_o <= 1'b0;
			dump_index_o <= 8'h00;
			dump_value_o <= 17'h00000;
			auto_table_o <= 1'b0;
		end else if (ce_i) begin
			dump_valid_o <= state == clgs_pkg::CLGS_DUMP; // RULE7
			dump_index_o <= walk_index;
			dump_value_o <= gain_table[walk_index];
			auto_table_o <= auto_mode;
		end
	end
endmodule

// ==== clgs_host_model.sv ====
`timescale 1ns/1ps
module clgs_host_model (
	// clock
	input  wire logic        clk_i,
	// requests
	output logic             wr_o,
	output logic             rd_o,
	output logic [15:0]      addr_o,
	output logic [31:0]      wdata_o,
	// answers
	input  wire logic [31:0] rdata_i,
	input  wire logic        rd_valid_i
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 16'h5a5a;
		wdata_o = 32'h0;
	end
	// idle bus shows inverted values so a stale address cannot pass
	task automatic write(input logic [15:0] a, input logic [31:0] d);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
		// one idle cycle so back-to-back calls never flip the strobe twice in one step
		@(negedge clk_i);
	endtask
	task automatic read(input logic [15:0] a, output logic [31:0] d);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		// the answer stands only one cycle after the strobe edge
		d = rd_valid_i ? rdata_i : 32'hdeadbeef;
		rd_o = 1'b0;
		addr_o = ~a;
		@(negedge clk_i);
	endtask
endmodule

// ==== clgs_monitor.sv ====
`timescale 1ns/1ps
module clgs_monitor (
	// controls
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        ce_i,
	input wire logic        rd_i,
	input wire logic        loop_tick_i,
	input wire logic        gain_table_dump_i,
	input wire logic [31:0] drive_peak_current_i,
	input wire logic [31:0] motor_peak_current_i,
	input wire logic [1:0]  operating_mode_select_i,
	// results
	input wire logic        rd_valid_o,
	input wire logic [31:0] rdata_o,
	input wire logic        dump_valid_o,
	input wire logic [7:0]  dump_index_o,
	input wire logic [7:0]  active_index_o,
	input wire logic signed [31:0] vel_ff_term_o,
	input wire logic signed [31:0] q_current_limited_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_stepping;
		ce_i && dump_valid_o && dump_index_o != 8'hff;
	endsequence
	sequence s_last;
		ce_i && dump_valid_o && dump_index_o == 8'hff;
	endsequence
	property p_rd_ans;
		ce_i && rd_i |=> rd_valid_o;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
	property p_rd_idle;
		ce_i && !rd_i |=> !rd_valid_o && rdata_o == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without request");
	property p_dump_start;
		$rose(dump_valid_o) |-> dump_index_o == 8'h00 && $past(gain_table_dump_i, 2);
	endproperty
	a_dump_start: assert property (p_dump_start) else $error("dump start wrong");
	property p_dump_step;
		s_stepping |=> dump_valid_o && dump_index_o == $past(dump_index_o) + 8'h01;
	endproperty
	a_dump_step: assert property (p_dump_step) else $error("dump order wrong");
	property p_dump_end;
		s_last |=> !dump_valid_o;
	endproperty
	a_dump_end: assert property (p_dump_end) else $error("dump length wrong");
	property p_idx_sat;
		ce_i && loop_tick_i && drive_peak_current_i == 32'h0 |=> active_index_o == 8'hff;
	endproperty
	a_idx_sat: assert property (p_idx_sat) else $error("index not saturated");
	property p_vff_off;
		ce_i && loop_tick_i && operating_mode_select_i != 2'h2 |=> vel_ff_term_o == 32'sh0;
	endproperty
	a_vff_off: assert property (p_vff_off) else $error("feed-forward outside mode");
	property p_lim_lo;
		ce_i && loop_tick_i |=> q_current_limited_o >= -$signed($past(motor_peak_current_i));
	endproperty
	a_lim_lo: assert property (p_lim_lo) else $error("command below motor peak");
endmodule
bind clgs_current_loop_gain_schedule clgs_monitor i_mon (.clk_i, .reset_n_i, .ce_i, .rd_i,
	.loop_tick_i, .gain_table_dump_i, .drive_peak_current_i, .motor_peak_current_i,
	.operating_mode_select_i, .rd_valid_o, .rdata_o, .dump_valid_o, .dump_index_o,
	.active_index_o, .vel_ff_term_o, .q_current_limited_o);

// ==== clgs_pkg.sv ====
package clgs_pkg;
	// register offsets
	localparam logic [15:0] VEL_FF_GAIN_OFS   = 16'h01ca;
	localparam logic [15:0] NEG_LIMIT_OFS     = 16'h01cc;
	localparam logic [15:0] TABLE_POINTER_OFS = 16'h04ca;
	localparam logic [15:0] TABLE_ENTRY_OFS   = 16'h04cc;

	// table geometry and scaling
	localparam int          TABLE_DEPTH       = 256;
	localparam int          INDEX_W           = 8;
	localparam logic [7:0]  INDEX_MAX         = 8'hff;
	localparam logic [7:0]  INDEX_PER_PEAK    = 8'h9d;
	localparam logic [16:0] PCT_FULL          = 17'h186a0;
	localparam int          PCT_W             = 17;

	// gain ranges, fixed point in thousandths
	localparam logic [31:0] KP_MAX            = 32'h001e8480;
	localparam logic [31:0] VFF_MAX           = 32'h000007d0;
	localparam logic [31:0] VFF_UNITY         = 32'h000003e8;

	// auto table fill enable and feed-forward mode
	localparam logic [15:0] MEMVER_MIN        = 16'h001e;
	localparam logic [1:0]  OPMODE_POSITION   = 2'h2;

	// reset values
	localparam logic [7:0]  POINTER_RESET     = 8'h00;
	localparam logic [16:0] ENTRY_RESET       = 17'h00000;
	localparam logic [31:0] VFF_RESET         = 32'h00000000;

	typedef enum logic [2:0] {
		CLGS_IDLE = 3'b001,
		CLGS_DUMP = 3'b010,
		CLGS_FILL = 3'b100
	} clgs_state_type;
endpackage

// ==== tb_current_loop_gain_schedule.sv ====
`timescale 1ns/1ps
module tb_current_loop_gain_schedule;
	logic clk_i = 0, reset_n_i = 0, ce_i = 1, loop_tick_i = 0, gain_table_dump_i = 0;
	logic motor_auto_setup_i = 0, wr_i, rd_i, rd_valid_o, dump_valid_o, auto_table_o;
	logic [1:0] operating_mode_select_i = 2'h2;
	logic [15:0] addr_i, feedback_memory_version_i = 16'h0000;
	logic [31:0] wdata_i, rdata_o, sched_prop_gain_o, q_prop_gain_i = 32'h0003a980;
	logic [31:0] drive_peak_current_i = 32'h00002328, motor_peak_current_i = 32'h000186a0;
	logic [31:0] foldback_limit_i = 32'h000186a0, motor_saturation_inductance_i = 32'h000003e8;
	logic signed [31:0] q_current_command_i = 0, vel_ff_nominal_i = 32'sh3e8;
	logic signed [31:0] q_current_limited_o, vel_ff_term_o;
	logic [7:0] active_index_o, dump_index_o;
	logic [16:0] dump_value_o;
	int n_fail = 0, checks_done = 0;
	always #5 clk_i = ~clk_i;
	clgs_current_loop_gain_schedule i_dut (.clk_i, .reset_n_i, .ce_i, .wr_i, .rd_i, .addr_i,
		.wdata_i, .rdata_o, .rd_valid_o, .q_prop_gain_i, .drive_peak_current_i,
		.motor_peak_current_i, .foldback_limit_i, .feedback_memory_version_i,
		.motor_auto_setup_i, .motor_saturation_inductance_i, .operating_mode_select_i,
		.loop_tick_i, .q_current_command_i, .vel_ff_nominal_i, .sched_prop_gain_o,
		.active_index_o, .q_current_limited_o, .vel_ff_term_o, .gain_table_dump_i,
		.dump_valid_o, .dump_index_o, .dump_value_o, .auto_table_o);
	clgs_host_model i_host (.clk_i, .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i),
		.wdata_o(wdata_i), .rdata_i(rdata_o), .rd_valid_i(rd_valid_o));
	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] d;
		i_host.read(a, d);
		check_val(what, exp, d);
	endtask
	task automatic tick(input logic signed [31:0] cmd);
		q_current_command_i = cmd;
		loop_tick_i = 1'b1;
		@(negedge clk_i);
		loop_tick_i = 1'b0;
		@(negedge clk_i);
	endtask
	task automatic t_resets();
		rd_chk("pointer", clgs_pkg::TABLE_POINTER_OFS, 32'h0);
		rd_chk("entry", clgs_pkg::TABLE_ENTRY_OFS, 32'h0);
		rd_chk("vff", clgs_pkg::VEL_FF_GAIN_OFS, 32'h0);
		rd_chk("neg limit", clgs_pkg::NEG_LIMIT_OFS, 32'hffffdcd8);
		rd_chk("unmapped", 16'h0000, 32'h0);
	endtask
	task automatic t_gain();
		i_host.write(clgs_pkg::TABLE_POINTER_OFS, 32'h64);
		i_host.write(clgs_pkg::TABLE_ENTRY_OFS, 32'h00030d40);
		rd_chk("entry clamp", clgs_pkg::TABLE_ENTRY_OFS, 32'h000186a0);
		i_host.write(clgs_pkg::TABLE_ENTRY_OFS, 32'h0000c350);
		rd_chk("entry", clgs_pkg::TABLE_ENTRY_OFS, 32'h0000c350);
		tick(32'sd5733);
		check_val("index", 32'd100, 32'(active_index_o));
		check_val("gain", 32'h0001d4c0, sched_prop_gain_o);
		tick(32'sd20000);
		check_val("index sat", 32'hff, 32'(active_index_o));
		check_val("gain 255", 32'h0, sched_prop_gain_o);
		drive_peak_current_i = 32'h00000000;
		tick(32'sd1);
		check_val("index zero peak", 32'hff, 32'(active_index_o));
		drive_peak_current_i = 32'h00002328;
	endtask
	task automatic t_vff();
		i_host.write(clgs_pkg::VEL_FF_GAIN_OFS, 32'hbb8);
		rd_chk("vff clamp", clgs_pkg::VEL_FF_GAIN_OFS, 32'h7d0);
		i_host.write(clgs_pkg::VEL_FF_GAIN_OFS, 32'h5dc);
		tick(32'sd0);
		check_val("vff term", 32'h5dc, vel_ff_term_o);
		operating_mode_select_i = 2'h1;
		tick(32'sd0);
		check_val("vff off", 32'h0, vel_ff_term_o);
		operating_mode_select_i = 2'h2;
		ce_i = 1'b0;
		i_host.write(clgs_pkg::VEL_FF_GAIN_OFS, 32'h3e8);
		ce_i = 1'b1;
		rd_chk("vff frozen", clgs_pkg::VEL_FF_GAIN_OFS, 32'h5dc);
	endtask
	task automatic t_limit();
		i_host.write(clgs_pkg::NEG_LIMIT_OFS, 32'h5);
		rd_chk("neg clamp", clgs_pkg::NEG_LIMIT_OFS, 32'h0);
		i_host.write(clgs_pkg::NEG_LIMIT_OFS, 32'hfffff448);
		tick(-32'sd5000);
		check_val("neg clip", 32'hfffff448, q_current_limited_o);
		foldback_limit_i = 32'h7d0;
		tick(32'sd5000);
		check_val("foldback clip", 32'h7d0, q_current_limited_o);
		foldback_limit_i = 32'h000186a0;
	endtask
	task automatic t_dump();
		gain_table_dump_i = 1'b1;
		@(negedge clk_i);
		gain_table_dump_i = 1'b0;
		repeat (4) if (dump_valid_o !== 1'b1) @(negedge clk_i);
		for (int i = 0; i < 256; i++) begin
			check_val("dump index", 32'(i), 32'(dump_index_o));
			if (i == 100) check_val("dump value", 32'h0000c350, 32'(dump_value_o));
			@(negedge clk_i);
		end
		check_val("dump end", 32'h0, 32'(dump_valid_o));
	endtask
	// the fill sweeps the whole table, so allow it two full passes
	task automatic t_auto();
		feedback_memory_version_i = clgs_pkg::MEMVER_MIN;
		motor_auto_setup_i = 1'b1;
		repeat (600) @(negedge clk_i);
		check_val("auto", 32'h1, 32'(auto_table_o));
		i_host.write(clgs_pkg::TABLE_ENTRY_OFS, 32'h1234);
		rd_chk("entry ro", clgs_pkg::TABLE_ENTRY_OFS, 32'h000186a0);
		i_host.write(clgs_pkg::TABLE_POINTER_OFS, 32'hc8);
		rd_chk("entry slope", clgs_pkg::TABLE_ENTRY_OFS, 32'h0000dea8);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk_i);
		reset_n_i = 1'b1;
		t_resets();
		t_gain();
		t_vff();
		t_limit();
		t_dump();
		t_auto();
		tally_and_finish();
	end
	initial begin
		#100us;
		n_fail++;
		tally_and_finish();
	end
endmodule
